// File: bench/bcs_line_model.sv
`timescale 1ns/1ps
module bcs_line_model #(
  parameter int RISE = 6
) (
  input wire logic sys_clk, // system clock
  input wire logic slave_low, // a slave holds the line low
  input wire logic pullup_on, // device pullup transistor
  output logic line_pin // level seen by the device
);
  int cnt_q = 0;
  // resistor alone needs a few cycles to reach threshold
  always @(posedge sys_clk) begin
    if (slave_low) begin
      cnt_q <= 0;
    end else if (cnt_q < RISE) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign line_pin = !slave_low && (pullup_on || cnt_q >= RISE);
endmodule // bcs_line_model

// File: bench/bcs_regs_bench.sv
`timescale 1ns/1ps
module bcs_regs_bench
  import bcs_pkg::*;
;
  logic sys_clk, reset, scl_pin, line_pin, cmd_valid, rd_addr_ack, slave_low;
  bcs_cmd_t cmd;
  bcs_evt_t eng_evt;
  logic cmd_done_q, cmd_nak_q, bus_speed_select, eng_abort_q, pullup_drive_q, ext_n;
  logic [7:0] rd_data_q;
  logic [10:0] slot_limit_q;
  int miscompares = 0;
  int cmp_count = 0;
  bcs_regs dut (.sys_clk(sys_clk), .reset(reset), .scl_pin(scl_pin), .line_pin(line_pin),
    .cmd_valid(cmd_valid), .cmd(cmd), .rd_addr_ack(rd_addr_ack), .eng_evt(eng_evt),
    .eng_read_data(8'h5A), .cmd_done_q(cmd_done_q), .cmd_nak_q(cmd_nak_q),
    .rd_data_q(rd_data_q), .bus_speed_select(bus_speed_select), .slot_limit_q(slot_limit_q),
    .eng_abort_q(eng_abort_q), .pullup_drive_q(pullup_drive_q),
    .ext_pullup_control_n(ext_n));
  bcs_line_model line (.sys_clk(sys_clk), .slave_low(slave_low), .pullup_on(pullup_drive_q),
    .line_pin(line_pin));
  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] a, input logic [15:0] b, input string m);
    cmp_count++;
    if (a !== b) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one command per scl rise; scl held high 200 ns, then low 350 ns before the next command
  task automatic do_cmd(input logic [7:0] c, input logic [7:0] p, input logic nak);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd = '{c, p};
    tick(4);
    scl_pin = 1'b1;
    while (cmd_done_q !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk({cmd_done_q, cmd_nak_q, eng_abort_q}, {1'b1, nak, c == CMD_DEVICE_RESET},
      "command answer");
    tick(1);
    cmd_valid = 1'b0;
    scl_pin = 1'b0;
    tick(3);
  endtask
  // host read: address ack sampled at scl rise
  task automatic rd(input logic [7:0] e);
    rd_addr_ack = 1'b1;
    tick(4);
    scl_pin = 1'b1;
    tick(4);
    scl_pin = 1'b0;
    rd_addr_ack = 1'b0;
    chk(rd_data_q, e, "read byte");
  endtask
  task automatic ev(input logic [9:0] v);
    eng_evt = bcs_evt_t'(v);
    tick(1);
    eng_evt = '0;
    tick(1);
  endtask
  task automatic low(input logic v);
    slave_low = v;
    tick(8);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, run takes about 530 cycles
  initial begin
    tick(20000);
    miscompares++;
    stop_test;
  end
  initial begin
    reset = 1'b1;
    scl_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    rd_addr_ack = 1'b0;
    eng_evt = '0;
    slave_low = 1'b0;
    tick(8);
    reset = 1'b0;
    tick(2);
    rd(8'h18);
    do_cmd(CMD_SET_POINTER, PTR_CODE_CONFIG, 1'b0);
    rd(8'h00);
    do_cmd(CMD_WRITE_CONFIG, 8'h01, 1'b1);
    do_cmd(CMD_WRITE_CONFIG, 8'hD2, 1'b1);
    rd(8'h00);
    do_cmd(CMD_WRITE_CONFIG, 8'hE1, 1'b0);
    rd(8'h01);
    do_cmd(CMD_SET_POINTER, 8'h55, 1'b1);
    do_cmd(CMD_SET_POINTER, PTR_CODE_DATA, 1'b0);
    rd(8'h5A);
    do_cmd(CMD_SET_POINTER, PTR_CODE_STATUS, 1'b0);
    rd(8'h08);
    do_cmd(CMD_WRITE_CONFIG, 8'h78, 1'b0);
    chk({bus_speed_select, slot_limit_q}, {1'b1, SLOT_OD_CYC}, "overdrive");
    // presence then short, both sampled with the line held low
    low(1'b1);
    ev(10'h020);
    low(1'b0);
    do_cmd(CMD_SET_POINTER, PTR_CODE_STATUS, 1'b0);
    rd(8'h0A);
    low(1'b1);
    ev(10'h010);
    ev(10'h020);
    low(1'b0);
    rd(8'h0C);
    // triplet: first bit low, second high, direction one
    low(1'b1);
    ev(10'h008);
    low(1'b0);
    ev(10'h004);
    ev(10'h003);
    rd(8'hCC);
    eng_evt.busy = 1'b1;
    rd(8'hCD);
    do_cmd(CMD_WRITE_CONFIG, 8'hE1, 1'b1);
    eng_evt.busy = 1'b0;
    // active pullup on, no strong: timed drive only
    do_cmd(CMD_WRITE_CONFIG, 8'hE1, 1'b0);
    chk({bus_speed_select, slot_limit_q}, {1'b0, SLOT_STD_CYC}, "standard");
    low(1'b1);
    slave_low = 1'b0;
    ev(10'h080);
    tick(8);
    chk({pullup_drive_q, ext_n}, 2'b11, "active pullup on");
    tick(60);
    chk(pullup_drive_q, 1'b0, "active pullup timed out");
    low(1'b1);
    slave_low = 1'b0;
    ev(10'h0C0);
    tick(8);
    chk(pullup_drive_q, 1'b0, "no pullup after presence");
    // strong pullup with active pullup kept
    do_cmd(CMD_WRITE_CONFIG, 8'hA5, 1'b0);
    low(1'b1);
    slave_low = 1'b0;
    ev(10'h080);
    tick(80);
    chk({pullup_drive_q, ext_n}, 2'b10, "strong pullup held");
    ev(10'h100);
    chk({pullup_drive_q, ext_n}, 2'b01, "strong pullup ended");
    do_cmd(CMD_SET_POINTER, PTR_CODE_CONFIG, 1'b0);
    rd(8'h01);
    do_cmd(CMD_DEVICE_RESET, 8'h00, 1'b0);
    rd(8'h18);
    do_cmd(CMD_SET_POINTER, PTR_CODE_CONFIG, 1'b0);
    rd(8'h00);
    stop_test;
  end
endmodule // bcs_regs_bench

// File: bench/bcs_regs_sva.sv
`timescale 1ns/1ps
module bcs_regs_sva
  import bcs_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic reset, // sync reset
  input wire bcs_cmd_t cmd, // command word
  input wire bcs_evt_t eng_evt, // engine events
  input wire logic cmd_done_q, // command taken
  input wire logic cmd_nak_q, // command refused
  input wire logic [7:0] rd_data_q, // read byte
  input wire logic bus_speed_select, // speed bit
  input wire logic [10:0] slot_limit_q, // slot length
  input wire logic pullup_drive_q, // pullup on
  input wire logic ext_pullup_control_n // external pullup, low active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // readback one cycle after an accepted write, upper nibble masked
  AST_CFG_WRITE: assert property (
    cmd_done_q && !cmd_nak_q && cmd.code == CMD_WRITE_CONFIG
    |=> rd_data_q == {4'h0, $past(cmd.param[3:0])}) else $error("config readback wrong");
  AST_CFG_REJECT: assert property (
    cmd_done_q && cmd_nak_q && cmd.code == CMD_WRITE_CONFIG
    |-> ##2 bus_speed_select == $past(bus_speed_select, 2)) else $error("refused write took");
  AST_DEV_RESET: assert property (
    cmd_done_q && !cmd_nak_q && cmd.code == CMD_DEVICE_RESET && !eng_evt.busy
    |=> (rd_data_q[7:4] == 4'h1 && rd_data_q[2:0] == 3'h0) ##1 !bus_speed_select)
    else $error("device reset state wrong");
  AST_SLOT: assert property (
    $changed(bus_speed_select)
    |-> ##[0:1] slot_limit_q == (bus_speed_select ? SLOT_OD_CYC : SLOT_STD_CYC))
    else $error("slot length wrong");
  AST_EXT_DRIVE: assert property (
    !ext_pullup_control_n |-> pullup_drive_q) else $error("external pullup without drive");
  AST_STRONG_END: assert property (
    !ext_pullup_control_n && eng_evt.cmd_start |-> ##[1:3] ext_pullup_control_n)
    else $error("strong pullup kept after command");
  // sixteen cycles cover line rise, sync and wait of a wrongly started pullup
  AST_NO_APU: assert property (
    eng_evt.release_edge && eng_evt.release_no_apu && !pullup_drive_q
    |=> !pullup_drive_q [*8] ##1 !pullup_drive_q [*8])
    else $error("pullup after presence or short");
  AST_NAK_DONE: assert property (
    cmd_nak_q |-> cmd_done_q) else $error("refusal without done");
  AST_DONE_PULSE: assert property (
    cmd_done_q |=> !cmd_done_q) else $error("done longer than a cycle");
endmodule // bcs_regs_sva

bind bcs_regs bcs_regs_sva u_sva (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
  .eng_evt(eng_evt), .cmd_done_q(cmd_done_q), .cmd_nak_q(cmd_nak_q), .rd_data_q(rd_data_q),
  .bus_speed_select(bus_speed_select), .slot_limit_q(slot_limit_q),
  .pullup_drive_q(pullup_drive_q), .ext_pullup_control_n(ext_pullup_control_n));

// File: common/bcs_pkg.sv
package bcs_pkg;
  // function command codes
  localparam logic [7:0] CMD_DEVICE_RESET = 8'hF0;
  localparam logic [7:0] CMD_SET_POINTER = 8'hE1;
  localparam logic [7:0] CMD_WRITE_CONFIG = 8'hD2;
  // pointer codes carried by the set-pointer command
  localparam logic [7:0] PTR_CODE_STATUS = 8'hF0;
  localparam logic [7:0] PTR_CODE_DATA = 8'hE1;
  localparam logic [7:0] PTR_CODE_CONFIG = 8'hC3;
  // configuration field positions and reset value
  localparam int CFG_APU_BIT = 0;
  localparam int CFG_ZERO_BIT = 1;
  localparam int CFG_SPU_BIT = 2;
  localparam int CFG_SPEED_BIT = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // status field positions
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_PRESENCE_BIT = 1;
  localparam int STS_SHORT_BIT = 2;
  localparam int STS_LEVEL_BIT = 3;
  localparam int STS_RESET_BIT = 4;
  localparam int STS_SBR_BIT = 5;
  localparam int STS_TSB_BIT = 6;
  localparam int STS_DIR_BIT = 7;
  // timing, clock is 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLOT_STD_NS = 65000;
  localparam int SLOT_OD_NS = 10000;
  localparam int APU_ON_NS = 2500;
  // longest times round down, least times round up
  localparam logic [10:0] SLOT_STD_CYC = 11'(SLOT_STD_NS / CLK_PERIOD_NS);
  localparam logic [10:0] SLOT_OD_CYC = 11'(SLOT_OD_NS / CLK_PERIOD_NS);
  localparam logic [7:0] APU_ON_CYC = 8'((APU_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    PTR_STATUS = 2'b00,
    PTR_DATA = 2'b01,
    PTR_CONFIG = 2'b10
  } bcs_ptr_t;

  typedef enum logic [1:0] {
    PU_IDLE = 2'b00,
    PU_WAIT = 2'b01,
    PU_ACTIVE = 2'b10,
    PU_STRONG = 2'b11
  } bcs_pu_state_t;

  typedef struct packed {
    logic speed;
    logic strong_pullup_enable;
    logic active_pullup_enable;
  } bcs_cfg_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] param;
  } bcs_cmd_t;

  // events from the waveform engine, all single-cycle pulses except busy
  typedef struct packed {
    logic busy;
    logic cmd_start;
    logic release_edge;
    logic release_no_apu;
    logic presence_smp;
    logic short_smp;
    logic bit1_smp;
    logic bit2_smp;
    logic dir_valid;
    logic dir;
  } bcs_evt_t;
endpackage

// File: hw/bcs_pullup.sv
`timescale 1ns/1ps
module bcs_pullup
  import bcs_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic release_edge, // pulldown just ended
  input wire logic release_no_apu, // presence end or short recovery
  input wire logic line_high, // synchronised line above threshold
  input wire logic apu_en, // active pullup selected
  input wire logic spu_en, // strong pullup armed
  input wire logic strong_end, // command, strong bit cleared, device reset
  output logic drive_q, // pullup transistor on
  output logic ext_n_q, // external mosfet control, low active
  output logic strong_done_q // pulse when strong pullup ends
);
  bcs_pu_state_t state_q;
  logic strong_q;
  logic [7:0] cnt_q;
  logic start;

  // an edge ending a presence pulse or a short gets the resistor only
  assign start = release_edge && !release_no_apu && (apu_en || spu_en);

  // sequencing of one rising edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= PU_IDLE;
      strong_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (strong_q && strong_end) begin
      state_q <= PU_IDLE;
      strong_q <= 1'b0;
    end else begin
      unique case (state_q)
        PU_IDLE: begin
          if (start) begin
            state_q <= PU_WAIT;
            strong_q <= spu_en;
          end
        end
        PU_WAIT: begin
          // resistor lifts the line until it crosses the threshold
          if (line_high) begin
            state_q <= PU_ACTIVE;
            cnt_q <= APU_ON_CYC - 8'h01;
          end
        end
        PU_ACTIVE: begin
          if (cnt_q == 8'h00) begin
            state_q <= strong_q ? PU_STRONG : PU_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        PU_STRONG: begin
          state_q <= PU_STRONG; // held until strong_end
        end
      endcase
    end
  end

  // outputs registered; the mosfet is on through the active and strong phases of a strong-armed edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drive_q <= 1'b0;
      ext_n_q <= 1'b1;
      strong_done_q <= 1'b0;
    end else begin
      // transistor and mosfet let go on the same edge when the strong phase ends
      drive_q <= ((state_q == PU_ACTIVE) || (state_q == PU_STRONG)) &&
                 !(strong_q && strong_end);
      ext_n_q <= !(strong_q && !strong_end &&
                   ((state_q == PU_ACTIVE) || (state_q == PU_STRONG)));
      strong_done_q <= strong_q && strong_end;
    end
  end
endmodule // bcs_pullup

// File: hw/bcs_regs.sv
`timescale 1ns/1ps
module bcs_regs
  import bcs_pkg::*;
(
  input wire logic sys_clk, // system clock, 20 MHz
  input wire logic reset, // power-on reset, synchronous, active high
  input wire logic scl_pin, // host serial clock pin
  input wire logic line_pin, // bus line level pin
  input wire logic cmd_valid, // command held until done
  input wire bcs_cmd_t cmd, // command code and parameter
  input wire logic rd_addr_ack, // host addressed us in read mode
  input wire bcs_evt_t eng_evt, // waveform engine events
  input wire logic [7:0] eng_read_data, // read data register content
  output logic cmd_done_q, // command taken, one-cycle pulse
  output logic cmd_nak_q, // command refused, with cmd_done_q
  output logic [7:0] rd_data_q, // byte under the read pointer
  output logic bus_speed_select, // overdrive when high
  output logic [10:0] slot_limit_q, // slot length in cycles for the engine
  output logic eng_abort_q, // device reset, stop bus activity
  output logic pullup_drive_q, // internal pullup transistor on
  output logic ext_pullup_control_n // external mosfet, low while strong pullup
);
  logic scl_n_s, line_s, scl_n_prev_q, scl_rise;
  logic taken_q;
  logic take;
  logic dev_rst;
  logic cfg_ok;
  logic spu_done;
  logic strong_end;
  bcs_cfg_t cfg_q;
  bcs_ptr_t ptr_q;
  logic busy_q, presence_q, short_q, level_q, rst_flag_q, sbr_q, tsb_q, dir_q;
  logic [7:0] status_word;
  logic [7:0] config_word;

  // pins cross into the system clock domain
  bcs_sync2 #(
    .W(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({~scl_pin, line_pin}),
    .sync_q({scl_n_s, line_s})
  );

  // edge finder on the second stage; clock kept inverted so the cleared reset state
  // matches an idle-high serial clock and no false rise follows reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_n_prev_q <= 1'b0;
    end else begin
      scl_n_prev_q <= scl_n_s;
    end
  end

  assign scl_rise = !scl_n_s && scl_n_prev_q;

  // a held command is acted on once, at the acknowledge rising edge
  assign take = cmd_valid && !taken_q && scl_rise;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      taken_q <= 1'b0;
    end else if (!cmd_valid) begin
      taken_q <= 1'b0;
    end else if (take) begin
      taken_q <= 1'b1;
    end
  end

  // decode helpers
  function automatic logic ptr_code_ok(input logic [7:0] code);
    ptr_code_ok = (code == PTR_CODE_STATUS) || (code == PTR_CODE_DATA) ||
                  (code == PTR_CODE_CONFIG);
  endfunction

  function automatic logic nibble_guard_ok(input logic [7:0] val);
    nibble_guard_ok = (val[7:4] == ~val[3:0]) && !val[CFG_ZERO_BIT];
  endfunction

  assign dev_rst = take && (cmd.code == CMD_DEVICE_RESET);
  // guarded write, and refused outright while the bus is busy
  assign cfg_ok = take && (cmd.code == CMD_WRITE_CONFIG) && !busy_q &&
                  nibble_guard_ok(cmd.param);

  // command answers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_done_q <= 1'b0;
      cmd_nak_q <= 1'b0;
      eng_abort_q <= 1'b0;
    end else begin
      cmd_done_q <= take;
      eng_abort_q <= dev_rst;
      unique case (cmd.code)
        CMD_DEVICE_RESET: cmd_nak_q <= 1'b0;
        CMD_SET_POINTER: cmd_nak_q <= take && !ptr_code_ok(cmd.param);
        CMD_WRITE_CONFIG: cmd_nak_q <= take && !cfg_ok;
        default: cmd_nak_q <= take;
      endcase
    end
  end

  // read pointer follows the last executed instruction
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ptr_q <= PTR_STATUS;
    end else if (dev_rst) begin
      ptr_q <= PTR_STATUS;
    end else if (take && (cmd.code == CMD_SET_POINTER) && ptr_code_ok(cmd.param)) begin
      unique case (cmd.param)
        PTR_CODE_DATA: ptr_q <= PTR_DATA;
        PTR_CODE_CONFIG: ptr_q <= PTR_CONFIG;
        default: ptr_q <= PTR_STATUS;
      endcase
    end else if (cfg_ok) begin
      ptr_q <= PTR_CONFIG;
    end else if (eng_evt.cmd_start) begin
      ptr_q <= PTR_STATUS; // bus commands leave it on status for polling
    end
  end

  // strong pullup ends on a bus command, a cleared strong bit or device reset
  assign strong_end = eng_evt.cmd_start || dev_rst ||
                      (cfg_ok && !cmd.param[CFG_SPU_BIT]);

  // configuration register
  always_ff @(posedge sys_clk) begin
    if (reset || dev_rst) begin
      cfg_q <= bcs_cfg_t'(3'(CFG_RESET));
    end else if (cfg_ok) begin
      cfg_q.active_pullup_enable <= cmd.param[CFG_APU_BIT];
      cfg_q.strong_pullup_enable <= cmd.param[CFG_SPU_BIT];
      cfg_q.speed <= cmd.param[CFG_SPEED_BIT];
    end else if (spu_done) begin
      cfg_q.strong_pullup_enable <= 1'b0;
    end
  end

  // rising edge and strong pullup control
  bcs_pullup u_pullup (
    .sys_clk(sys_clk),
    .reset(reset),
    .release_edge(eng_evt.release_edge),
    .release_no_apu(eng_evt.release_no_apu),
    .line_high(line_s),
    .apu_en(cfg_q.active_pullup_enable),
    .spu_en(cfg_q.strong_pullup_enable),
    .strong_end(strong_end),
    .drive_q(pullup_drive_q),
    .ext_n_q(ext_pullup_control_n),
    .strong_done_q(spu_done)
  );

  // speed select and slot length for the engine
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_speed_select <= 1'b0;
      slot_limit_q <= SLOT_STD_CYC;
    end else begin
      bus_speed_select <= cfg_q.speed;
      slot_limit_q <= cfg_q.speed ? SLOT_OD_CYC : SLOT_STD_CYC;
    end
  end

  // busy mirrors the engine; cleared at once on device reset
  always_ff @(posedge sys_clk) begin
    if (reset || dev_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= eng_evt.busy;
    end
  end

  // presence and short; a sample in the device reset cycle still lands
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      presence_q <= 1'b0;
      short_q <= 1'b0;
    end else if (eng_evt.short_smp) begin
      short_q <= !line_s;
      if (!line_s) begin
        presence_q <= 1'b0;
      end
    end else if (eng_evt.presence_smp) begin
      presence_q <= !line_s && !short_q;
    end else if (dev_rst) begin
      presence_q <= 1'b0;
      short_q <= 1'b0;
    end
  end

  // line level: sampled on a read address ack, status selected only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level_q <= 1'b0;
    end else if (rd_addr_ack && scl_rise && (ptr_q == PTR_STATUS)) begin
      level_q <= line_s;
    end
  end

  // reset flag: set by either reset, cleared by a config write
  always_ff @(posedge sys_clk) begin
    if (reset || dev_rst) begin
      rst_flag_q <= 1'b1;
    end else if (cfg_ok) begin
      rst_flag_q <= 1'b0;
    end
  end

  // bit results; event wins over a simultaneous device reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sbr_q <= 1'b0;
      tsb_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      if (eng_evt.bit1_smp) begin
        sbr_q <= line_s;
      end else if (dev_rst) begin
        sbr_q <= 1'b0;
      end
      if (eng_evt.bit2_smp) begin
        tsb_q <= line_s;
      end else if (dev_rst) begin
        tsb_q <= 1'b0;
      end
      if (eng_evt.dir_valid) begin
        dir_q <= eng_evt.dir;
      end else if (dev_rst) begin
        dir_q <= 1'b0;
      end
    end
  end

  // status layout
  always_comb begin
    status_word = 8'h00;
    status_word[STS_BUSY_BIT] = busy_q;
    status_word[STS_PRESENCE_BIT] = presence_q && !short_q;
    status_word[STS_SHORT_BIT] = short_q;
    status_word[STS_LEVEL_BIT] = level_q;
    status_word[STS_RESET_BIT] = rst_flag_q;
    status_word[STS_SBR_BIT] = sbr_q;
    status_word[STS_TSB_BIT] = tsb_q;
    status_word[STS_DIR_BIT] = dir_q;
  end

  // config reads with the guard nibble as zero
  always_comb begin
    config_word = 8'h00;
    config_word[CFG_APU_BIT] = cfg_q.active_pullup_enable;
    config_word[CFG_SPU_BIT] = cfg_q.strong_pullup_enable;
    config_word[CFG_SPEED_BIT] = cfg_q.speed;
  end

  // read data mux, registered so the front end sees a stable byte
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data_q <= 8'h00;
    end else begin
      unique case (ptr_q)
        PTR_STATUS: rd_data_q <= status_word;
        PTR_DATA: rd_data_q <= eng_read_data;
        PTR_CONFIG: rd_data_q <= config_word;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end
endmodule // bcs_regs

// File: hw/bcs_sync2.sv
`timescale 1ns/1ps
module bcs_sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic [W-1:0] async_in, // from another domain
  output logic [W-1:0] sync_q // safe to use
);
  logic [W-1:0] meta_q;

  // two flops; the first is only read by the second
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule // bcs_sync2
